// ==== verilog/apm_pkg.sv ====
// apm_pkg: constants, types and helpers of the adc power-mode controller.
// assumes a 100 MHz core clock and an 8-bit control word that arrives
// msb first on the serial data input at the start of each 16-clock frame.
//
// Overview of operation
// - mode bits 00,01,10,11 select power modes one, two, three and four.
// - mode one: off while chip select high, full power while it is low.
// - mode two: always fully powered, chip select and conversion end ignored.
// - mode three: full shutdown at each conversion end, whatever chip select.
// - mode four: standby after each conversion, internal reference stays up.
// - reference-disable zero uses internal reference; one disables it.
// - input pick bit zero converts input zero, one converts input one.
// - two-input select set: two-input operation, supply is the reference.
package apm_pkg;

   // core clock and wake-up times
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         WAKE_FULL_NS  = 5000;
   localparam int         WAKE_STBY_NS  = 1000;
   localparam logic [8:0] WAKE_FULL_CYC =
      9'((WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] WAKE_STBY_CYC =
      9'((WAKE_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // serial frame layout
   localparam int         CODE_BITS       = 12;
   localparam logic [4:0] LAST_CTRL_EDGE  = 5'h07;
   localparam logic [4:0] FIRST_CODE_EDGE = 5'h04;
   localparam logic [4:0] LAST_FRAME_EDGE = 5'h0F;
   localparam logic [4:0] FRAME_END       = 5'h10;
   localparam logic [3:0] TOP_BIT_INDEX   = 4'hF;

   // control word fields
   localparam int         REF_DISABLE_POS          = 5;
   localparam int         ONE_OR_TWO_INPUT_SELECT  = 4;
   localparam int         INPUT_PICK_BIT           = 3;
   localparam int         POWER_MODE_HIGH_BIT      = 1;
   localparam int         POWER_MODE_LOW_BIT       = 0;
   localparam logic [7:0] CTRL_RESET               = 8'h00;

   typedef enum logic [1:0] {
      MODE_CS_SLEEP = 2'b00,
      MODE_ALWAYS   = 2'b01,
      MODE_AUTO_OFF = 2'b10,
      MODE_AUTO_SBY = 2'b11
   } apm_mode_t;

   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_STBY = 2'b01,
      ST_WAKE = 2'b10,
      ST_FULL = 2'b11
   } apm_state_t;

   // power-mode decode of a control word
   function automatic apm_mode_t mode_of(input logic [7:0] word);
      mode_of = apm_mode_t'({word[POWER_MODE_HIGH_BIT],
                             word[POWER_MODE_LOW_BIT]});
   endfunction

endpackage

// ==== verilog/apm_link_if.sv ====
// apm_link_if: signals between the serial-clock logic and the core logic.
// assumes toggles are resynchronised by the receiving domain.
`timescale 1ns/1ps
interface apm_link_if;
   logic [7:0]                  ctrl_word;
   logic                        ctrl_flag;
   logic                        done_flag;
   logic [apm_pkg::CODE_BITS-1:0] result_code;

   modport link (output ctrl_word, output ctrl_flag, output done_flag,
                 input  result_code);
   modport core (input  ctrl_word, input  ctrl_flag, input  done_flag,
                 output result_code);
endinterface

// ==== verilog/apm_link.sv ====
// apm_link: serial-clock side; takes the control word, shifts out the code.
// assumes the host holds chip select low for whole 16-clock frames and
// the serial clock is still outside frames.
`timescale 1ns/1ps
module apm_link (
   input  wire logic serial_clk,
   input  wire logic reset,
   input  wire logic chip_sel_n,
   input  wire logic data_in,
   output logic      data_out,
   output logic      data_out_en_n,
   apm_link_if.link  lnk
);

   logic [4:0]                     edge_cnt;
   logic [6:0]                     rx_shift;
   logic [apm_pkg::CODE_BITS-1:0]  tx_code;
   wire                            frame_clear;
   wire  [3:0]                     tx_idx;
   wire                            tx_bit;

   ////////////////////////////////////////////////////////////////////////
   // frame clear: chip select high ends the frame without a clock edge
   assign frame_clear = reset | chip_sel_n;
   assign tx_idx      = 4'(apm_pkg::TOP_BIT_INDEX - edge_cnt[3:0]);
   assign tx_bit      = (edge_cnt >= apm_pkg::FIRST_CODE_EDGE) &&
                        (edge_cnt <  apm_pkg::FRAME_END) &&
                        tx_code[tx_idx];

   // edge counter, input shifter; code is latched once per frame
   always_ff @(posedge serial_clk or posedge frame_clear) begin
      if (frame_clear) begin
         edge_cnt <= 5'h00;
         rx_shift <= 7'h00;
         tx_code  <= 12'h000;
      end else begin
         if (edge_cnt != apm_pkg::FRAME_END)
            edge_cnt <= 5'(edge_cnt + 5'h01);
         rx_shift <= {rx_shift[5:0], data_in};
         if (edge_cnt == 5'h00)
            tx_code <= lnk.result_code; // quasi-static since last done
      end
   end

   // control word and event toggles survive between frames
   always_ff @(posedge serial_clk or posedge reset) begin
      if (reset) begin
         lnk.ctrl_word <= apm_pkg::CTRL_RESET;
         lnk.ctrl_flag <= 1'b0;
         lnk.done_flag <= 1'b0;
      end else begin
         if (edge_cnt == apm_pkg::LAST_CTRL_EDGE) begin
            lnk.ctrl_word <= {rx_shift, data_in};
            lnk.ctrl_flag <= ~lnk.ctrl_flag;
         end
         if (edge_cnt == apm_pkg::LAST_FRAME_EDGE)
            lnk.done_flag <= ~lnk.done_flag; // conversion ends at edge 16
      end
   end

   // output changes on falling edges so the host samples it on rising
   always_ff @(negedge serial_clk or posedge frame_clear) begin
      if (frame_clear) begin
         data_out      <= 1'b0;
         data_out_en_n <= 1'b1;
      end else begin
         data_out      <= tx_bit;
         data_out_en_n <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks in the serial clock domain
   property p_ctrl_take;
      @(posedge serial_clk) disable iff (frame_clear)
      edge_cnt == apm_pkg::LAST_CTRL_EDGE |=>
         lnk.ctrl_flag != $past(lnk.ctrl_flag) &&
         lnk.ctrl_word == {$past(rx_shift), $past(data_in)};
   endproperty
   a_ctrl_take: assert property (p_ctrl_take)
      else $error("control word not taken at eighth edge");

   // only reset may cancel this check: the toggle shows at the next frame's
   // first edge, and the select that ends a frame would otherwise abort it
   property p_conv_done;
      @(posedge serial_clk) disable iff (reset)
      edge_cnt == apm_pkg::LAST_FRAME_EDGE |=>
         lnk.done_flag != $past(lnk.done_flag) ##1
         $stable(lnk.done_flag);
   endproperty
   a_conv_done: assert property (p_conv_done)
      else $error("conversion end not flagged once at sixteenth edge");

endmodule

// ==== verilog/apm_ctrl.sv ====
// apm_ctrl: power-mode controller of a two-input 12-bit serial converter.
// assumes serial pins come straight from the host and the two input codes
// come from the converter core on the core clock.
`timescale 1ns/1ps
module apm_ctrl (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        clock_en,
   input  wire logic        serial_clk,
   input  wire logic        chip_sel_n,
   input  wire logic        data_in,
   input  wire logic [11:0] analog_input_zero_code,
   input  wire logic [11:0] analog_input_one_code,
   output logic             data_out,
   output logic             data_out_en_n,
   output logic [1:0]       power_mode,
   output logic             power_full,
   output logic             standby,
   output logic             ref_internal_on,
   output logic             pick_input_one,
   output logic             two_input_mode,
   output logic             ref_from_supply,
   output logic             result_valid,
   output logic [11:0]      result_code
);

   apm_link_if              lnk ();
   logic [2:0]              cs_sync;
   logic [2:0]              ctrl_sync;
   logic [2:0]              done_sync;
   logic [7:0]              ctrl_applied;
   apm_pkg::apm_state_t     state;
   apm_pkg::apm_state_t     next_state;
   logic [8:0]              wait_cnt;
   logic [8:0]              next_wait;
   wire                     cs_high;
   wire                     cs_fall;
   wire                     ctrl_evt;
   wire                     done_evt;
   wire  [7:0]              next_ctrl;
   apm_pkg::apm_mode_t      mode;
   apm_pkg::apm_mode_t      next_mode;

   ////////////////////////////////////////////////////////////////////////
   // serial side runs on the host's clock
   apm_link u_apm_link (
      .serial_clk    (serial_clk),
      .reset         (reset),
      .chip_sel_n    (chip_sel_n),
      .data_in       (data_in),
      .data_out      (data_out),
      .data_out_en_n (data_out_en_n),
      .lnk           (lnk.link)
   );

   assign lnk.result_code = result_code;

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; the third stage only serves edge detection
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cs_sync   <= 3'h7;
         ctrl_sync <= 3'h0;
         done_sync <= 3'h0;
      end else if (clock_en) begin
         cs_sync   <= {cs_sync[1:0], chip_sel_n};
         ctrl_sync <= {ctrl_sync[1:0], lnk.ctrl_flag};
         done_sync <= {done_sync[1:0], lnk.done_flag};
      end
   end

   // events; the control word is steady long before its toggle lands
   assign cs_high   = cs_sync[1];
   assign cs_fall   = cs_sync[2] & ~cs_sync[1];
   assign ctrl_evt  = ctrl_sync[2] ^ ctrl_sync[1];
   assign done_evt  = done_sync[2] ^ done_sync[1];
   assign next_ctrl = ctrl_evt ? lnk.ctrl_word : ctrl_applied;
   assign mode      = apm_pkg::mode_of(ctrl_applied);
   assign next_mode = apm_pkg::mode_of(next_ctrl);

   ////////////////////////////////////////////////////////////////////////
   // power state; a wake in progress counts down first, modes may override
   always_comb begin
      next_state = state;
      next_wait  = wait_cnt;
      if (state == apm_pkg::ST_WAKE) begin
         if (wait_cnt <= 9'h001)
            next_state = apm_pkg::ST_FULL;
         else
            next_wait = 9'(wait_cnt - 9'h001);
      end
      unique case (mode)
         apm_pkg::MODE_CS_SLEEP: begin
            if (cs_high) begin
               next_state = apm_pkg::ST_OFF;
            end else if (state == apm_pkg::ST_OFF ||
                         state == apm_pkg::ST_STBY) begin
               next_state = apm_pkg::ST_WAKE;
               next_wait  = apm_pkg::WAKE_FULL_CYC;
            end
         end
         apm_pkg::MODE_ALWAYS: begin
            next_state = apm_pkg::ST_FULL;
         end
         apm_pkg::MODE_AUTO_OFF: begin
            if (done_evt) begin
               next_state = apm_pkg::ST_OFF;
            end else if (cs_fall && (state == apm_pkg::ST_OFF ||
                                     state == apm_pkg::ST_STBY)) begin
               next_state = apm_pkg::ST_WAKE;
               next_wait  = apm_pkg::WAKE_FULL_CYC;
            end
         end
         apm_pkg::MODE_AUTO_SBY: begin
            if (done_evt) begin
               next_state = apm_pkg::ST_STBY;
            end else if (cs_fall && state == apm_pkg::ST_STBY) begin
               next_state = apm_pkg::ST_WAKE;
               next_wait  = apm_pkg::WAKE_STBY_CYC;
            end else if (cs_fall && state == apm_pkg::ST_OFF) begin
               next_state = apm_pkg::ST_WAKE;
               next_wait  = apm_pkg::WAKE_FULL_CYC;
            end
         end
      endcase
   end

   // state and control copy
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state        <= apm_pkg::ST_OFF;
         wait_cnt     <= 9'h000;
         ctrl_applied <= apm_pkg::CTRL_RESET;
      end else if (clock_en) begin
         state        <= next_state;
         wait_cnt     <= next_wait;
         ctrl_applied <= next_ctrl;
      end
   end

   // outputs are registered from next values so they track the state
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         power_mode      <= 2'h0;
         power_full      <= 1'b0;
         standby         <= 1'b0;
         ref_internal_on <= 1'b0;
         pick_input_one  <= 1'b0;
         two_input_mode  <= 1'b0;
         ref_from_supply <= 1'b0;
      end else if (clock_en) begin
         power_mode      <= next_mode;
         power_full      <= next_state == apm_pkg::ST_FULL;
         standby         <= next_state == apm_pkg::ST_STBY;
         ref_internal_on <= ~next_ctrl[apm_pkg::REF_DISABLE_POS] &&
                            next_state != apm_pkg::ST_OFF;
         pick_input_one  <= next_ctrl[apm_pkg::INPUT_PICK_BIT];
         two_input_mode  <= next_ctrl[apm_pkg::ONE_OR_TWO_INPUT_SELECT];
         ref_from_supply <= next_ctrl[apm_pkg::ONE_OR_TWO_INPUT_SELECT];
      end
   end

   // result of the finished conversion; a conversion that ran before
   // wake-up ended is kept but flagged, since the core may give garbage
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         result_code  <= 12'h000;
         result_valid <= 1'b0;
      end else if (clock_en && done_evt) begin
         result_code  <= ctrl_applied[apm_pkg::INPUT_PICK_BIT] ?
                         analog_input_one_code :
                         analog_input_zero_code;
         result_valid <= state == apm_pkg::ST_FULL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks in the core clock domain
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_mode_apply;
      clock_en && ctrl_evt |=>
         power_mode == {$past(lnk.ctrl_word[1]), $past(lnk.ctrl_word[0])};
   endproperty
   a_mode_apply: assert property (p_mode_apply)
      else $error("new power mode not applied after control word");

   property p_cs_sleep;
      clock_en && mode == apm_pkg::MODE_CS_SLEEP && cs_high && !ctrl_evt
      |=> !power_full && !standby && state == apm_pkg::ST_OFF;
   endproperty
   a_cs_sleep: assert property (p_cs_sleep)
      else $error("mode one not powered down with chip select high");

   property p_cs_wake;
      clock_en && mode == apm_pkg::MODE_CS_SLEEP && !cs_high &&
      !ctrl_evt && state == apm_pkg::ST_OFF
      |=> state == apm_pkg::ST_WAKE && wait_cnt == 9'h1F4;
   endproperty
   a_cs_wake: assert property (p_cs_wake)
      else $error("mode one did not start a 500-cycle wake");

   property p_always_on;
      clock_en && mode == apm_pkg::MODE_ALWAYS && !ctrl_evt
      |=> power_full ##1 (power_full || !clock_en || ctrl_evt);
   endproperty
   a_always_on: assert property (p_always_on)
      else $error("mode two left full power");

   property p_auto_off;
      clock_en && mode == apm_pkg::MODE_AUTO_OFF && done_evt
      |=> state == apm_pkg::ST_OFF && !ref_internal_on;
   endproperty
   a_auto_off: assert property (p_auto_off)
      else $error("mode three not shut down at conversion end");

   property p_auto_sby;
      clock_en && mode == apm_pkg::MODE_AUTO_SBY && done_evt && !ctrl_evt
      |=> standby && ref_internal_on ==
          !ctrl_applied[apm_pkg::REF_DISABLE_POS];
   endproperty
   a_auto_sby: assert property (p_auto_sby)
      else $error("mode four standby lost the reference");

   property p_ref_rule;
      ref_internal_on |-> !ctrl_applied[apm_pkg::REF_DISABLE_POS] &&
                          state != apm_pkg::ST_OFF;
   endproperty
   a_ref_rule: assert property (p_ref_rule)
      else $error("internal reference on while disabled or off");

   property p_pick;
      pick_input_one == ctrl_applied[apm_pkg::INPUT_PICK_BIT] &&
      two_input_mode == ref_from_supply;
   endproperty
   a_pick: assert property (p_pick)
      else $error("input pick or supply reference out of step");

   property p_two_input;
      two_input_mode |-> ctrl_applied[apm_pkg::ONE_OR_TWO_INPUT_SELECT];
   endproperty
   a_two_input: assert property (p_two_input)
      else $error("two-input mode without its select bit");

endmodule

// ==== verif/apm_host.sv ====
// apm_host: host controller model that frames the serial link of apm_ctrl.
// assumes the serial clock stands low outside frames and that the caller
// keeps at least four core clocks of idle time between frames.
`timescale 1ns/1ps
module apm_host (
   output logic serial_clk,
   output logic chip_sel_n,
   output logic data_in,
   input  wire logic data_out,
   input  wire logic data_out_en_n
);

   ////////////////////////////////////////////////////////////////////////
   // idle levels: clock still, frame select released
   initial begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
      data_in    = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // pull select low with no clock, e.g. to let the converter wake
   task automatic select();
      #3 chip_sel_n = 1'b0;
   endtask

   task automatic deselect();
      #3 chip_sel_n = 1'b1;
      data_in = ~data_in; // released line shows no stale value
   endtask

   // one frame of nedge clocks; the control word goes out msb first and
   // the returned vector holds output bit k at position 15-k
   task automatic shift(input  logic [7:0]  word,
                        input  int          nedge,
                        output logic [15:0] bits,
                        output logic        en_mid);
      int i;
      #3 chip_sel_n = 1'b0;
      bits   = 16'h0000;
      en_mid = 1'b1;
      #1 bits[15] = data_out;
      for (i = 0; i < nedge; i++) begin
         // data changes after the falling edge, sampled on the rising one
         data_in = (i < 8) ? word[7-i] : ~data_in;
         #39 serial_clk = 1'b1;
         #40 serial_clk = 1'b0;
         #1;
         if (i < 15) begin
            bits[14-i] = data_out;
         end
         if (i == 0) begin
            en_mid = data_out_en_n;
         end
      end
      #40 chip_sel_n = 1'b1;
      data_in = ~data_in;
   endtask

endmodule

// ==== verif/apm_ctrl_test.sv ====
// apm_ctrl_test: self-checking bench of the power-mode controller.
// assumes the host model owns the serial pins and the bench owns the
// core-side inputs; expected values follow the control-word layout.
`timescale 1ns/1ps
module apm_ctrl_test;

   localparam logic [11:0] CODE_ZERO = 12'hA5C;
   localparam logic [11:0] CODE_ONE  = 12'h3C9;

   logic        clock;
   logic        reset;
   logic        clock_en;
   logic        serial_clk;
   logic        chip_sel_n;
   logic        data_in;
   logic [11:0] zero_code;
   logic [11:0] one_code;
   logic        data_out;
   logic        data_out_en_n;
   logic [1:0]  power_mode;
   logic        power_full;
   logic        standby;
   logic        ref_internal_on;
   logic        pick_input_one;
   logic        two_input_mode;
   logic        ref_from_supply;
   logic        result_valid;
   logic [11:0] result_code;
   logic [15:0] fb;
   logic        en_mid;
   int          error_cnt;
   int          checked;

   ////////////////////////////////////////////////////////////////////////
   // design and host model
   apm_ctrl u_apm_ctrl (
      .clock                  (clock),
      .reset                  (reset),
      .clock_en               (clock_en),
      .serial_clk             (serial_clk),
      .chip_sel_n             (chip_sel_n),
      .data_in                (data_in),
      .analog_input_zero_code (zero_code),
      .analog_input_one_code  (one_code),
      .data_out               (data_out),
      .data_out_en_n          (data_out_en_n),
      .power_mode             (power_mode),
      .power_full             (power_full),
      .standby                (standby),
      .ref_internal_on        (ref_internal_on),
      .pick_input_one         (pick_input_one),
      .two_input_mode         (two_input_mode),
      .ref_from_supply        (ref_from_supply),
      .result_valid           (result_valid),
      .result_code            (result_code)
   );

   apm_host u_apm_host (
      .serial_clk    (serial_clk),
      .chip_sel_n    (chip_sel_n),
      .data_in       (data_in),
      .data_out      (data_out),
      .data_out_en_n (data_out_en_n)
   );

   ////////////////////////////////////////////////////////////////////////
   // core clock, 100 MHz
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers: waits, comparison, closing report
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // full frame, then room for the core to apply word and result
   task automatic frame(input logic [7:0] word);
      u_apm_host.shift(word, 16, fb, en_mid);
      cyc(10);
   endtask

   task automatic results();
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      error_cnt = 0;
      checked   = 0;
      reset     = 1'b1;
      clock_en  = 1'b1;
      zero_code = CODE_ZERO;
      one_code  = CODE_ONE;
      cyc(3);
      chk(power_mode, 2'b00);
      chk(data_out_en_n, 1'b1);
      reset <= 1'b0;
      cyc(4);
      // always-on mode, internal reference, input zero
      frame(8'h01);
      chk(power_mode, 2'b01);
      chk(power_full, 1'b1);
      chk(ref_internal_on, 1'b1);
      chk(pick_input_one, 1'b0);
      chk(result_code, CODE_ZERO);
      chk(result_valid, 1'b1);
      cyc(20);
      chk(power_full, 1'b1);
      // reference off, two inputs, input one; previous code shifted out
      frame(8'h39);
      chk(fb, {4'h0, CODE_ZERO});
      chk(en_mid, 1'b0);
      chk(data_out_en_n, 1'b1);
      chk(ref_internal_on, 1'b0);
      chk(two_input_mode, 1'b1);
      chk(ref_from_supply, 1'b1);
      chk(pick_input_one, 1'b1);
      chk(result_code, CODE_ONE);
      frame(8'h01);
      chk(fb, {4'h0, CODE_ONE});
      // a frame cut after five clocks leaves the mode alone
      u_apm_host.shift(8'h02, 5, fb, en_mid);
      cyc(10);
      chk(power_mode, 2'b01);
      // frozen core keeps the old mode until the clock enable returns
      clock_en <= 1'b0;
      frame(8'h00);
      chk(power_mode, 2'b01);
      clock_en <= 1'b1;
      cyc(10);
      chk(power_mode, 2'b00);
      chk(power_full, 1'b0);
      // select-driven mode: wake on select low, off on select high
      u_apm_host.select();
      cyc(490);
      chk(power_full, 1'b0);
      cyc(25);
      chk(power_full, 1'b1);
      u_apm_host.deselect();
      cyc(8);
      chk(power_full, 1'b0);
      // auto shutdown: a frame started cold converts while still waking
      frame(8'h02);
      chk(power_mode, 2'b10);
      chk(result_valid, 1'b0);
      chk(power_full, 1'b0);
      chk(standby, 1'b0);
      chk(ref_internal_on, 1'b0);
      // host lets the wake time pass before clocking the frame
      u_apm_host.select();
      cyc(600);
      frame(8'h02);
      chk(result_valid, 1'b1);
      chk(power_full, 1'b0);
      // standby mode keeps the reference up after each conversion
      frame(8'h03);
      chk(power_mode, 2'b11);
      chk(standby, 1'b1);
      chk(ref_internal_on, 1'b1);
      chk(power_full, 1'b0);
      u_apm_host.select();
      cyc(90);
      chk(power_full, 1'b0);
      cyc(25);
      chk(power_full, 1'b1);
      frame(8'h03);
      chk(result_valid, 1'b1);
      chk(standby, 1'b1);
      // reset in mid-run returns to the select-driven mode
      reset <= 1'b1;
      cyc(3);
      chk(power_mode, 2'b00);
      chk(standby, 1'b0);
      reset <= 1'b0;
      cyc(4);
      // first frame after the second release starts from a cleared result
      frame(8'h01);
      chk(fb, 16'h0000);
      chk(power_mode, 2'b01);
      results();
   end

endmodule
